// >>> design/dik_pkg.sv
// package for the device identity and serial key block
package dik_pkg;
    localparam logic [7:0] SFR_VARIANT_CODE = 8'hAD;
    localparam logic [7:0] SFR_FAMILY_CODE  = 8'hB5;
    localparam logic [7:0] SFR_REVISION     = 8'hB6;
    // serial key occupies the top four bytes of its memory segment
    localparam logic [7:0] KEY_BASE_ADDR    = 8'hFC;
    localparam logic [7:0] KEY_TOP_ADDR     = 8'hFF;
    localparam int         KEY_BYTES        = 4;
    localparam logic [7:0] REV_C            = 8'h02;
    localparam logic [7:0] READ_IDLE        = 8'h00;

    typedef enum logic [1:0] {
        DIK_SEG_XRAM = 2'b01,
        DIK_SEG_IRAM = 2'b10
    } dik_seg_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dik_req_t;

    typedef struct packed {
        logic [7:0] sfr_rdata;
        logic       sfr_hit;
        logic [7:0] mem_rdata;
        logic       mem_hit;
        logic [7:0] dbg_rdata;
        logic       dbg_hit;
        logic [31:0] key;
    } dik_state_t;
endpackage : dik_pkg

// >>> design/dik_top.sv
// identification registers and factory serial key store
// Functional notes
// RULE_01: firmware can read family, variant and revision codes from special-function registers.
// RULE_02: revision C or later parts hold a 32-bit factory serial key unique to each device.
// RULE_03: on external-RAM variants the key sits at FC..FF with the most significant byte at FF.
// RULE_04: on internal-RAM variants the key sits at indirect FC..FF with the most significant byte at FF.
// RULE_05: internal-RAM variants return key bytes on indirect data reads.
// RULE_06: external-RAM variants return key bytes on external-memory move reads.
// RULE_07: the debug port can read the key bytes on every variant.
// RULE_08: firmware may overwrite the key bytes, and every reset restores the factory value.
// RULE_09: firmware using those bytes as storage should set them after each reset.
// RULE_10: an 8-bit read-only family code sits at special-function address B5.
// RULE_11: an 8-bit read-only variant code sits at special-function address AD.
// RULE_12: writes to either identification register are ignored.
`timescale 1ns/1ps
`default_nettype none
module dik_top
    import dik_pkg::*;
#(
    parameter logic [7:0]  FAMILY_CODE  = 8'h5A,        // arbitrary value
    parameter logic [7:0]  VARIANT_CODE = 8'h01,        // arbitrary value
    parameter logic [7:0]  REVISION     = 8'h02,
    parameter dik_seg_t    KEY_SEGMENT  = DIK_SEG_XRAM,
    parameter logic [31:0] FACTORY_KEY  = 32'h1234_5678 // arbitrary value
) (
    input  wire logic       MCLK_I,
    input  wire logic       RESETN_I,
    input  wire dik_req_t   SFR_REQ_I,
    input  wire dik_req_t   XRAM_REQ_I,
    input  wire dik_req_t   IRAM_REQ_I,
    input  wire logic       DBG_RD_I,
    input  wire logic [7:0] DBG_ADDR_I,
    output logic [7:0]      SFR_RDATA_O,
    output logic            SFR_HIT_O,
    output logic [7:0]      MEM_RDATA_O,
    output logic            MEM_HIT_O,
    output logic [7:0]      DBG_RDATA_O,
    output logic            DBG_HIT_O
);
    // a key that is absent before revision C reads as zero
    localparam logic [31:0] KEY_INIT = (REVISION >= REV_C) ? FACTORY_KEY : 32'h0000_0000; // RULE_02

    // registered state and its next value
    dik_state_t state;
    dik_state_t next_state;

    // request of the segment that carries the key on this variant
    dik_req_t   mem_req;

    // per-lane address match, one bit per key byte
    logic [KEY_BYTES-1:0] mem_lane_hit;
    logic [KEY_BYTES-1:0] dbg_lane_hit;

    // decoded lane and qualified strobes
    logic [1:0] mem_idx;
    logic [1:0] dbg_idx;
    logic       mem_in_key;
    logic       dbg_in_key;
    logic       mem_rd_key;
    logic       mem_wr_key;
    logic       dbg_rd_key;
    logic [8:0] sfr_answer;

    // true for the four addresses that hold the key
    function automatic logic in_key(
        input logic [7:0] a
    );
        in_key = (a >= KEY_BASE_ADDR) && (a <= KEY_TOP_ADDR);
    endfunction : in_key

    // lane number of a one-hot lane match; no match gives lane 0,
    // which is harmless because the strobes are qualified separately
    function automatic logic [1:0] lane_of(
        input logic [3:0] hot
    );
        logic [1:0] l;
        l = 2'h0;
        unique case (hot)
            4'h1:    l = 2'h0;
            4'h2:    l = 2'h1;
            4'h4:    l = 2'h2;
            4'h8:    l = 2'h3;
            default: l = 2'h0;
        endcase
        lane_of = l;
    endfunction : lane_of

    // one byte of the key, picked by lane
    function automatic logic [7:0] key_byte(
        input logic [31:0] key,
        input logic [1:0]  lane
    );
        logic [7:0] b;
        b = 8'h00;
        unique case (lane)
            2'h0: b = key[7:0];
            2'h1: b = key[15:8];
            2'h2: b = key[23:16];
            2'h3: b = key[31:24];
        endcase
        key_byte = b;
    endfunction : key_byte

    // the key with one lane replaced, the other lanes kept
    function automatic logic [31:0] key_merge(
        input logic [31:0] key,
        input logic [1:0]  lane,
        input logic [7:0]  value
    );
        logic [31:0] k;
        k = key;
        unique case (lane)
            2'h0: k[7:0]   = value;
            2'h1: k[15:8]  = value;
            2'h2: k[23:16] = value;
            2'h3: k[31:24] = value;
        endcase
        key_merge = k;
    endfunction : key_merge

    // read answer of the identification registers as {hit, data};
    // there is no storage behind them, so a write has nothing to change
    function automatic logic [8:0] sfr_lookup(
        input logic [7:0] a
    );
        logic [8:0] r;
        r = {1'b0, READ_IDLE};
        unique case (a)
            SFR_FAMILY_CODE:  r = {1'b1, FAMILY_CODE};  // RULE_10 RULE_01
            SFR_VARIANT_CODE: r = {1'b1, VARIANT_CODE}; // RULE_11 RULE_01
            SFR_REVISION:     r = {1'b1, REVISION};     // RULE_01
            default:          r = {1'b0, READ_IDLE};
        endcase
        sfr_lookup = r;
    endfunction : sfr_lookup

    // only the segment this variant uses carries the key; the other
    // segment's memory lives outside this block and is not decoded here
    assign mem_req = (KEY_SEGMENT == DIK_SEG_IRAM) ? IRAM_REQ_I : XRAM_REQ_I; // RULE_05 RULE_06

    // the lowest key address carries the least significant byte
    for (genvar g = 0; g < KEY_BYTES; g++) begin : g_lane
        localparam logic [7:0] LANE_ADDR = KEY_BASE_ADDR + 8'(g);
        assign mem_lane_hit[g] = (mem_req.addr == LANE_ADDR);   // RULE_03 RULE_04
        assign dbg_lane_hit[g] = (DBG_ADDR_I == LANE_ADDR);
    end : g_lane

    always_comb begin
        next_state = state;

        mem_in_key = in_key(mem_req.addr);
        dbg_in_key = in_key(DBG_ADDR_I);
        mem_idx    = lane_of(mem_lane_hit);
        dbg_idx    = lane_of(dbg_lane_hit);
        mem_rd_key = mem_req.rd && mem_in_key;
        mem_wr_key = mem_req.wr && mem_in_key;
        dbg_rd_key = DBG_RD_I && dbg_in_key;

        // identification registers answer one cycle after a read
        sfr_answer = {1'b0, READ_IDLE};
        if (SFR_REQ_I.rd) begin
            sfr_answer = sfr_lookup(SFR_REQ_I.addr);
        end
        // sfr writes fall through untouched: the codes are constants RULE_12
        next_state.sfr_hit   = sfr_answer[8];
        next_state.sfr_rdata = sfr_answer[7:0];

        // a read in the same cycle as a write returns the old byte
        next_state.mem_hit   = 1'b0;
        next_state.mem_rdata = READ_IDLE;
        if (mem_rd_key) begin
            next_state.mem_rdata = key_byte(state.key, mem_idx); // RULE_05 RULE_06
            next_state.mem_hit   = 1'b1;
        end
        if (mem_wr_key) begin
            next_state.key = key_merge(state.key, mem_idx, mem_req.wdata); // RULE_08
        end

        // debugger sees the live bytes, including firmware overwrites
        next_state.dbg_hit   = 1'b0;
        next_state.dbg_rdata = READ_IDLE;
        if (dbg_rd_key) begin
            next_state.dbg_rdata = key_byte(state.key, dbg_idx); // RULE_07
            next_state.dbg_hit   = 1'b1;
        end
    end

    // reset reloads the factory key; whatever firmware stored is lost,
    // so the key bytes cannot serve as storage that survives a reset
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state     <= '0;
            state.key <= KEY_INIT; // RULE_08
        end else begin
            state <= next_state;
        end
    end

    // every output is a field of the registered state
    assign SFR_RDATA_O = state.sfr_rdata;
    assign SFR_HIT_O   = state.sfr_hit;
    assign MEM_RDATA_O = state.mem_rdata;
    assign MEM_HIT_O   = state.mem_hit;
    assign DBG_RDATA_O = state.dbg_rdata;
    assign DBG_HIT_O   = state.dbg_hit;
endmodule : dik_top
`default_nettype wire

// >>> tb/dik_monitor.sv
// port checker for the identity and serial key block
`timescale 1ns/1ps
`default_nettype none
module dik_monitor import dik_pkg::*; #(parameter logic [7:0] FAMILY_CODE = 8'h5A, VARIANT_CODE = 8'h01) (
    input wire logic       MCLK_I, RESETN_I, DBG_RD_I, SFR_HIT_O, MEM_HIT_O, DBG_HIT_O,
    input wire dik_req_t   SFR_REQ_I, XRAM_REQ_I,
    input wire logic [7:0] DBG_ADDR_I, SFR_RDATA_O, MEM_RDATA_O
);
    // only the default external segment is watched
    wire dik_req_t s = SFR_REQ_I, x = XRAM_REQ_I;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence wr_gap_rd;
        x.wr && x.addr >= KEY_BASE_ADDR ##1 !x.wr ##1 x.rd && !x.wr && x.addr == $past(x.addr, 2);
    endsequence
    fam_read_a:
    assert property (s.rd && s.addr == SFR_FAMILY_CODE |=> SFR_HIT_O && SFR_RDATA_O == FAMILY_CODE)
        else $error("family code wrong");
    var_read_a:
    assert property (s.rd && s.addr == SFR_VARIANT_CODE |=> SFR_HIT_O && SFR_RDATA_O == VARIANT_CODE)
        else $error("variant code wrong");
    sfr_quiet_a:
    assert property (!s.rd |=> !SFR_HIT_O && SFR_RDATA_O == 8'h00) else $error("sfr answer without read");
    key_hit_a:
    assert property (x.rd && x.addr >= KEY_BASE_ADDR |=> MEM_HIT_O) else $error("key read missed");
    key_miss_a:
    assert property (x.rd && x.addr < KEY_BASE_ADDR |=> !MEM_HIT_O) else $error("key hit out of range");
    dbg_hit_a:
    assert property (DBG_RD_I && DBG_ADDR_I >= KEY_BASE_ADDR |=> DBG_HIT_O) else $error("debug read missed");
    dbg_quiet_a:
    assert property (!DBG_RD_I |=> !DBG_HIT_O) else $error("debug hit without read");
    key_write_a:
    assert property (wr_gap_rd |=> MEM_RDATA_O == $past(x.wdata, 3)) else $error("key write lost");
endmodule : dik_monitor
bind dik_top dik_monitor #(.FAMILY_CODE(FAMILY_CODE), .VARIANT_CODE(VARIANT_CODE)) u_mon (.*);
`default_nettype wire

// >>> tb/dik_top_tb.sv
// bench for the identity and serial key block
`timescale 1ns/1ps
`default_nettype none
module dik_top_tb import dik_pkg::*;;
    localparam logic [31:0] KEY = 32'hA1B2_C3D4; // arbitrary value
    logic       MCLK_I = 0, RESETN_I = 0, dr = 0, SFR_HIT_O, MEM_HIT_O, DBG_HIT_O;
    logic [7:0] da = 0, SFR_RDATA_O, MEM_RDATA_O, DBG_RDATA_O;
    dik_req_t   sr = 0, xr = 0, ir = 0;
    int         bad_count = 0, checked = 0, cyc = 0;
    always #2.5 MCLK_I = ~MCLK_I;
    dik_top #(.FAMILY_CODE(8'h6C), .VARIANT_CODE(8'h3E), .FACTORY_KEY(KEY)) u_dut (.MCLK_I, .RESETN_I,
        .SFR_REQ_I(sr), .XRAM_REQ_I(xr), .IRAM_REQ_I(ir), .DBG_RD_I(dr), .DBG_ADDR_I(da),
        .SFR_RDATA_O, .SFR_HIT_O, .MEM_RDATA_O, .MEM_HIT_O, .DBG_RDATA_O, .DBG_HIT_O);
    task automatic acc(input int p, input logic w, input logic [7:0] a, d, e, input logic h);
        logic [8:0] r;
        @(posedge MCLK_I);
        if (p == 0) sr <= '{~w, w, a, d};
        else if (p == 1) xr <= '{~w, w, a, d};
        else if (p == 2) {dr, da} <= {1'b1, a};
        else ir <= '{~w, w, a, d};
        @(posedge MCLK_I);
        {sr, xr, ir, dr} <= 0;
        #1;
        r = p == 0 ? {SFR_HIT_O, SFR_RDATA_O} : p == 2 ? {DBG_HIT_O, DBG_RDATA_O} : {MEM_HIT_O, MEM_RDATA_O};
        checked++;
        if (r !== {h, e}) begin
            bad_count++;
            $display("MISMATCH port %0d addr %h exp %h seen %h", p, a, {h, e}, r);
        end
    endtask : acc
    task automatic t_ident;
        acc(0, 1, SFR_FAMILY_CODE, 8'h93, 0, 0);
        acc(0, 1, SFR_VARIANT_CODE, 8'hC1, 0, 0);
        acc(0, 0, SFR_FAMILY_CODE, 0, 8'h6C, 1);
        acc(0, 0, SFR_VARIANT_CODE, 0, 8'h3E, 1);
        acc(0, 0, SFR_REVISION, 0, REV_C, 1);
        $display("ident test done");
    endtask : t_ident
    task automatic t_key;
        for (int i = 0; i < 4; i++) begin
            acc(1, 0, KEY_BASE_ADDR + 8'(i), 0, KEY[8*i+:8], 1);
            acc(2, 0, KEY_BASE_ADDR + 8'(i), 0, KEY[8*i+:8], 1);
        end
        acc(1, 0, 8'hFB, 0, 0, 0);
        acc(1, 1, 8'hFD, 8'h96, 0, 0);
        acc(1, 0, 8'hFD, 0, 8'h96, 1);
        acc(2, 0, 8'hFD, 0, 8'h96, 1);
        @(posedge MCLK_I) RESETN_I <= 0;
        repeat (2) @(posedge MCLK_I);
        RESETN_I <= 1;
        acc(1, 0, 8'hFD, 0, KEY[15:8], 1);
        acc(3, 0, 8'hFC, 0, 0, 0);
        acc(3, 1, 8'hFC, 8'h3C, 0, 0);
        acc(1, 0, 8'hFC, 0, KEY[7:0], 1);
        acc(1, 1, 8'hFF, 8'h5B, 0, 0);
        acc(1, 0, 8'hFF, 0, 8'h5B, 1);
        $display("key test done");
    endtask : t_key
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    always @(posedge MCLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (20) @(posedge MCLK_I);
        RESETN_I <= 1;
        t_ident;
        t_key;
        give_verdict;
    end
endmodule : dik_top_tb
`default_nettype wire
